// ==== builtin_test_selector_display.v ====
/*
 * Built-in test selector: decodes the six-way test switch pack at reset,
 * runs the lamp-test and result display, and produces analyser gate,
 * window and sample strobes in signature modes.
 * Assumes switch, strobe and gate inputs synchronous to clk; the test
 * engines outside supply the fault code and its valid flag.
 */
`timescale 1ns/1ps
`include "selftest_defs.vh"

// Contract
// - All LEDs on 2 s, off 2 s
// - Left nibble test number, right nibble fault
// - Code 02 selects checksum test, number 2
// - Code 03 selects memory test, number 3
// - Code 04 selects timer test, number 4
// - Code 05 selects serial test, number 5
// - Position 6 OFF selects signature variant, no LEDs
// - All switches ON runs normal program
// - Chip select rise starts, fall stops window
// - Terminal-ready fall starts, rise stops window
// - Top address falls gate; strobe falling samples
// - One common 2.5 MHz system clock
// - Power-on or button reset restarts selection
// - Invalid pattern enters switch echo test
// - Pass shows zero fault code
module builtin_test_selector_display
#(
  parameter PHASE_CYCLES = `PHASE_CYCLES
)
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire       power_on_reset,
  input  wire       manual_reset_button,
  input  wire [5:0] test_select_switch_pack,
  input  wire [3:0] fault_code,
  input  wire       fault_valid,
  input  wire       switch_port_chip_select,
  input  wire       serial_ctrl_terminal_ready_a,
  input  wire       top_address_line,
  input  wire       read_strobe,
  output reg  [7:0] led,
  output reg  [2:0] mode,
  output reg  [3:0] test_number,
  output reg        system_reset,
  output reg        system_clock,
  output reg        sig_window,
  output reg        sig_start,
  output reg        sig_stop,
  output reg        sig_sample
);

  localparam ST_RESET = 2'h0;
  localparam ST_LAMP  = 2'h1;
  localparam ST_DARK  = 2'h2;
  localparam ST_SHOW  = 2'h3;

  reg [1:0]  state;
  reg [31:0] phase_cnt;
  reg [7:0]  sys_div;
  reg        btn_prev;
  wire       cs_rise;
  wire       cs_fall;
  wire       dtr_rise;
  wire       dtr_fall;
  wire       adr_rise;
  wire       adr_fall;
  wire       rd_rise;
  wire       rd_fall;
  wire       restart;

  // Switch ON pulls the line low, so the pack reads the code directly
  function [2:0] decode_mode;
    input [5:0] code;
    begin
      case (code)
        `SEL_NORMAL:                      decode_mode = `MODE_NORMAL;
        `SEL_CHECKSUM, `SEL_MEMORY,
        `SEL_TIMER, `SEL_SERIAL:          decode_mode = `MODE_SELFTEST;
        `SEL_CHECKSUM_SIG, `SEL_MEMORY_SIG: decode_mode = `MODE_SIG_CS;
        `SEL_TIMER_SIG, `SEL_SERIAL_SIG:  decode_mode = `MODE_SIG_DTR;
        `SEL_FREE_RUN:                    decode_mode = `MODE_FREE_RUN;
        default:                          decode_mode = `MODE_SWITCH;
      endcase
    end
  endfunction

  function [3:0] decode_tnum;
    input [5:0] code;
    begin
      case (code[4:0])
        5'h02:   decode_tnum = `TNUM_CHECKSUM;
        5'h03:   decode_tnum = `TNUM_MEMORY;
        5'h04:   decode_tnum = `TNUM_TIMER;
        5'h05:   decode_tnum = `TNUM_SERIAL;
        default: decode_tnum = 4'h0;
      endcase
    end
  endfunction

  function [7:0] show_value;
    input [2:0] md;
    input [3:0] tnum;
    input       valid;
    input [3:0] code;
    input [5:0] pack;
    begin
      case (md)
        `MODE_SELFTEST: show_value = {tnum, valid ? code : `FAULT_PASS};
        `MODE_SWITCH:   show_value = {2'b00, pack};
        default:        show_value = 8'h00;
      endcase
    end
  endfunction

  assign restart = power_on_reset | (manual_reset_button & ~btn_prev);

  gate_edge_detect u_cs (.clk(clk), .rst_n(rst_n), .sig(switch_port_chip_select),
                         .rise(cs_rise), .fall(cs_fall));
  gate_edge_detect u_dtr (.clk(clk), .rst_n(rst_n), .sig(serial_ctrl_terminal_ready_a),
                          .rise(dtr_rise), .fall(dtr_fall));
  gate_edge_detect u_adr (.clk(clk), .rst_n(rst_n), .sig(top_address_line),
                          .rise(adr_rise), .fall(adr_fall));
  gate_edge_detect u_rd (.clk(clk), .rst_n(rst_n), .sig(read_strobe),
                         .rise(rd_rise), .fall(rd_fall));

  // Single divider feeds processor, serial and timer alike
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      sys_div      <= 8'h00;
      system_clock <= 1'b0;
    end
    else if ({24'h000000, sys_div} == `SYS_DIV_HALF - 1)
    begin
      sys_div      <= 8'h00;
      system_clock <= ~system_clock;
    end
    else
      sys_div <= sys_div + 8'h01;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state        <= ST_RESET;
      phase_cnt    <= 32'h0;
      btn_prev     <= 1'b0;
      mode         <= `MODE_NORMAL;
      test_number  <= 4'h0;
      led          <= 8'h00;
      system_reset <= 1'b1;
    end
    else
    begin
      btn_prev     <= manual_reset_button;
      system_reset <= 1'b0;
      if (restart)
      begin
        state        <= ST_RESET;
        system_reset <= 1'b1;
        led          <= 8'h00;
      end
      else
      begin
        case (state)
          ST_RESET:
          begin
            // Mode and test number sampled once, so changing them needs a reset
            mode        <= decode_mode(test_select_switch_pack);
            test_number <= decode_tnum(test_select_switch_pack);
            phase_cnt   <= 32'h0;
            if (decode_mode(test_select_switch_pack) == `MODE_SELFTEST ||
                decode_mode(test_select_switch_pack) == `MODE_SWITCH)
            begin
              state <= ST_LAMP;
              led   <= 8'hFF;
            end
            else
            begin
              state <= ST_SHOW;
              led   <= 8'h00;
            end
          end
          ST_LAMP:
          begin
            if (phase_cnt == PHASE_CYCLES - 1)
            begin
              phase_cnt <= 32'h0;
              state     <= ST_DARK;
              led       <= 8'h00;
            end
            else
              phase_cnt <= phase_cnt + 32'h1;
          end
          ST_DARK:
          begin
            if (phase_cnt == PHASE_CYCLES - 1)
            begin
              phase_cnt <= 32'h0;
              state     <= ST_SHOW;
              // Result loaded here, else the dark phase lasts one cycle too long
              led       <= show_value(mode, test_number, fault_valid, fault_code,
                                      test_select_switch_pack);
            end
            else
              phase_cnt <= phase_cnt + 32'h1;
          end
          ST_SHOW:
          begin
            led <= show_value(mode, test_number, fault_valid, fault_code,
                              test_select_switch_pack);
          end
          default:
            state <= ST_RESET;
        endcase
      end
    end
  end

  // Analyser gating and sample strobes
  always @(posedge clk)
  begin
    if (!rst_n || restart)
    begin
      sig_window <= 1'b0;
      sig_start  <= 1'b0;
      sig_stop   <= 1'b0;
      sig_sample <= 1'b0;
    end
    else
    begin
      sig_start  <= 1'b0;
      sig_stop   <= 1'b0;
      sig_sample <= 1'b0;
      if (state == ST_SHOW)
      begin
        case (mode)
          `MODE_SIG_CS:
          begin
            if (cs_rise)
            begin
              sig_start  <= 1'b1;
              sig_window <= 1'b1;
            end
            else if (cs_fall && sig_window)
            begin
              sig_stop   <= 1'b1;
              sig_window <= 1'b0;
            end
            sig_sample <= rd_rise & sig_window;
          end
          `MODE_SIG_DTR:
          begin
            if (dtr_fall)
            begin
              sig_start  <= 1'b1;
              sig_window <= 1'b1;
            end
            else if (dtr_rise && sig_window)
            begin
              sig_stop   <= 1'b1;
              sig_window <= 1'b0;
            end
            sig_sample <= rd_rise & sig_window;
          end
          `MODE_FREE_RUN:
          begin
            // Same edge both opens and closes, so the window toggles
            if (adr_fall)
            begin
              sig_start  <= ~sig_window;
              sig_stop   <= sig_window;
              sig_window <= ~sig_window;
            end
            sig_sample <= rd_fall & sig_window;
          end
          default:
            sig_window <= 1'b0;
        endcase
      end
    end
  end

endmodule

// ==== builtin_test_selector_display_tb_top.sv ====
/* Testbench: restarts into each selection, judges mode, result and gating.
   Assumes a 10 ns clk and short lamp phases. */
`timescale 1ns/1ps
`include "selftest_defs.vh"
module builtin_test_selector_display_tb_top;
  reg        clk;
  reg        rst_n;
  reg        por;
  reg        btn;
  reg  [5:0] sw;
  reg  [3:0] fc;
  reg        fv;
  reg        cs;
  reg        dtr;
  reg        adr;
  reg        rd;
  wire [7:0] led;
  wire [2:0] mode;
  wire [3:0] tn;
  wire       win;
  wire       st;
  wire       smp;
  wire       sp;
  wire       ended;
  wire [7:0] cnt;
  integer    error_cnt;
  integer    check_count;
  integer    i;
  builtin_test_selector_display #(.PHASE_CYCLES(10)) dut
  (
    .clk(clk), .rst_n(rst_n), .power_on_reset(por), .manual_reset_button(btn),
    .test_select_switch_pack(sw), .fault_code(fc), .fault_valid(fv),
    .switch_port_chip_select(cs), .serial_ctrl_terminal_ready_a(dtr),
    .top_address_line(adr), .read_strobe(rd), .led(led), .mode(mode),
    .test_number(tn), .system_reset(), .system_clock(), .sig_window(win),
    .sig_start(st), .sig_stop(sp), .sig_sample(smp)
  );
  sig_analyser_model ana
  (
    .clk(clk), .sig_window(win), .sig_start(st), .sig_stop(sp), .sig_sample(smp),
    .samples(cnt), .ended(ended)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input string nm, input [7:0] s, input [7:0] e);
  begin
    check_count = check_count + 1;
    if (s !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %0s exp %h seen %h", nm, e, s);
    end
  end
  endtask
  task finish_test;
  begin
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // Power-on restart when p is set, push-button otherwise
  task restart(input [5:0] c, input p);
  begin
    sw = c;
    por = p;
    btn = !p;
    wt(1);
    por = 1'b0;
    btn = 1'b0;
    wt(40);
  end
  endtask
  task rd_pulses;
    repeat (3)
    begin
      rd = 1'b1;
      wt(3);
      rd = 1'b0;
      wt(3);
    end
  endtask
  task t_self;
  begin
    for (i = 2; i < 6; i = i + 1)
    begin
      restart(i[5:0], 1'b0);
      chk("mode", {5'h00, mode}, {5'h00, `MODE_SELFTEST});
      chk("tnum", {4'h0, tn}, {4'h0, i[3:0]});
      chk("led", led, {i[3:0], `FAULT_PASS});
    end
    fv = 1'b1;
    fc = 4'h9;
    restart(`SEL_TIMER, 1'b1);
    chk("fault", led, {`TNUM_TIMER, 4'h9});
    fv = 1'b0;
  end
  endtask
  task t_plain;
  begin
    restart(`SEL_NORMAL, 1'b1);
    chk("normal", {5'h00, mode}, {5'h00, `MODE_NORMAL});
    chk("nled", led, 8'h00);
    restart(6'h15, 1'b0);
    chk("echo", {5'h00, mode}, {5'h00, `MODE_SWITCH});
    chk("eled", led, 8'h15);
    sw = 6'h2A;
    wt(2);
    chk("live", led, 8'h2A);
    restart(`SEL_SWITCH, 1'b1);
    chk("sel8", {5'h00, mode}, {5'h00, `MODE_SWITCH});
    chk("led8", led, 8'h08);
  end
  endtask
  task t_gate(input [5:0] c, input [2:0] m);
  begin
    restart(c, 1'b0);
    chk("smode", {5'h00, mode}, {5'h00, m});
    chk("sled", led, 8'h00);
    cs = (m == `MODE_SIG_CS);
    dtr = (m == `MODE_SIG_CS);
    wt(4);
    chk("open", {7'h00, win}, 8'h01);
    rd_pulses;
    cs = 1'b0;
    dtr = 1'b1;
    wt(4);
    chk("count", cnt, 8'h03);
    chk("shut", {7'h00, win}, 8'h00);
    chk("stop", {7'h00, ended}, 8'h01);
  end
  endtask
  task t_free;
  begin
    restart(`SEL_FREE_RUN, 1'b0);
    chk("fmode", {5'h00, mode}, {5'h00, `MODE_FREE_RUN});
    adr = 1'b1;
    wt(2);
    adr = 1'b0;
    wt(4);
    chk("fopen", {7'h00, win}, 8'h01);
    rd_pulses;
    adr = 1'b1;
    wt(2);
    adr = 1'b0;
    wt(4);
    chk("fcount", cnt, 8'h03);
    chk("fshut", {7'h00, win}, 8'h00);
    chk("fstop", {7'h00, ended}, 8'h01);
  end
  endtask
  initial
  begin
    #100000;
    error_cnt = error_cnt + 1;
    finish_test;
  end
  initial
  begin
    {rst_n, por, btn, fv, cs, adr, rd} = 7'h00;
    dtr = 1'b1;
    sw = `SEL_NORMAL;
    fc = 4'h0;
    error_cnt = 0;
    check_count = 0;
    wt(10);
    rst_n = 1'b1;
    wt(4);
    t_self;
    t_plain;
    t_gate(`SEL_CHECKSUM_SIG, `MODE_SIG_CS);
    t_gate(`SEL_MEMORY_SIG, `MODE_SIG_CS);
    t_gate(`SEL_TIMER_SIG, `MODE_SIG_DTR);
    t_gate(`SEL_SERIAL_SIG, `MODE_SIG_DTR);
    t_free;
    finish_test;
  end
endmodule

// ==== gate_edge_detect.v ====
/*
 * Edge detector used for analyser gating and strobe edges.
 * Assumes the input is already synchronous to clk.
 */
`timescale 1ns/1ps
`include "selftest_defs.vh"

module gate_edge_detect
(
  input  wire clk,
  input  wire rst_n,
  input  wire sig,
  output reg  rise,
  output reg  fall
);

  reg prev;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      // Seeded from the pin so an idle-high line shows no false edge after reset
      prev <= sig;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      prev <= sig;
      rise <= sig & ~prev;
      fall <= ~sig & prev;
    end
  end

endmodule

// ==== selector_checker_properties.sv ====
/* Checker for the test selector outputs.
   Assumes one clk domain with synchronous active-low reset. */
`timescale 1ns/1ps
`include "selftest_defs.vh"
module selector_checker
#(
  parameter PHASE_CYCLES = `PHASE_CYCLES
)
(
  input wire       clk,
  input wire       rst_n,
  input wire       power_on_reset,
  input wire       system_reset,
  input wire       switch_port_chip_select,
  input wire       read_strobe,
  input wire [7:0] led,
  input wire [2:0] mode,
  input wire [3:0] test_number,
  input wire       system_clock,
  input wire       sig_window,
  input wire       sig_start,
  input wire       sig_stop,
  input wire       sig_sample
);
  reg [7:0]  last_led;
  reg [31:0] run;
  wire lamp = (mode == `MODE_SELFTEST);
  wire sig = (mode == `MODE_SIG_CS) || (mode == `MODE_SIG_DTR);
  // Length of the previous led value, so phase times need no long repetition
  always @(posedge clk)
  begin
    last_led <= led;
    run      <= (!rst_n || led != last_led) ? 32'h1 : run + 32'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence lit_over;
    lamp && led == 8'h00 && last_led == 8'hFF;
  endsequence
  sequence dark_over;
    lamp && led != 8'hFF && led != 8'h00 && last_led == 8'h00;
  endsequence
  a_lit_phase_len: assert property (lit_over |-> run == PHASE_CYCLES)
    else $error("lit phase length wrong");
  a_dark_phase_len: assert property (dark_over |-> run == PHASE_CYCLES)
    else $error("dark phase length wrong");
  a_left_nibble: assert property (dark_over |-> led[7:4] == test_number)
    else $error("test number not on left leds");
  a_sig_dark: assert property (sig |-> led == 8'h00)
    else $error("leds lit in signature mode");
  a_cs_opens: assert property (($rose(switch_port_chip_select) && mode == `MODE_SIG_CS
    && !sig_window) |-> ##2 sig_start)
    else $error("chip select rise did not start");
  a_strobe_sample: assert property (($rose(read_strobe) && sig && sig_window)
    |-> ##2 sig_sample)
    else $error("read strobe not sampled");
  a_start_opens: assert property (sig_start |-> sig_window ##1 !sig_start)
    else $error("start pulse wrong");
  a_stop_closes: assert property (sig_stop |-> !sig_window)
    else $error("stop left window open");
  a_plain_quiet: assert property ((mode == `MODE_NORMAL || lamp)
    |-> !sig_window && !sig_sample)
    else $error("gating outside signature mode");
  a_sysclk_half: assert property ($rose(system_clock) |-> ##20 $fell(system_clock))
    else $error("system clock half period wrong");
  a_restart_pulse: assert property (power_on_reset |=> system_reset)
    else $error("no reset pulse after power-on restart");
endmodule
bind builtin_test_selector_display selector_checker #(.PHASE_CYCLES(PHASE_CYCLES)) chk_i
(
  .clk(clk),
  .rst_n(rst_n),
  .power_on_reset(power_on_reset),
  .system_reset(system_reset),
  .switch_port_chip_select(switch_port_chip_select),
  .read_strobe(read_strobe),
  .led(led),
  .mode(mode),
  .test_number(test_number),
  .system_clock(system_clock),
  .sig_window(sig_window),
  .sig_start(sig_start),
  .sig_stop(sig_stop),
  .sig_sample(sig_sample)
);

// ==== selftest_defs.vh ====
/*
 * Constants for the built-in test selector and indicator block:
 * selection codes, test numbers, display timing.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SELFTEST_DEFS_VH
`define SELFTEST_DEFS_VH

// Selection code: bit 0 is position 1, ON reads as 0
`define SEL_NORMAL        6'h00
`define SEL_CHECKSUM      6'h02
`define SEL_MEMORY        6'h03
`define SEL_TIMER         6'h04
`define SEL_SERIAL        6'h05
`define SEL_SWITCH        6'h08
`define SEL_CHECKSUM_SIG  6'h22
`define SEL_MEMORY_SIG    6'h23
`define SEL_TIMER_SIG     6'h24
`define SEL_SERIAL_SIG    6'h25
`define SEL_FREE_RUN      6'h3F

`define TNUM_CHECKSUM     4'h2
`define TNUM_MEMORY       4'h3
`define TNUM_TIMER        4'h4
`define TNUM_SERIAL       4'h5
`define FAULT_PASS        4'h0

// Modes
`define MODE_NORMAL       3'h0
`define MODE_SELFTEST     3'h1
`define MODE_SIG_CS       3'h2
`define MODE_SIG_DTR      3'h3
`define MODE_FREE_RUN     3'h4
`define MODE_SWITCH       3'h5

`define CLK_HZ            100000000
`define PHASE_TIME_MS     2000
`define PHASE_CYCLES      (`CLK_HZ / 1000 * `PHASE_TIME_MS)
`define SYS_CLK_HZ        2500000
`define SYS_DIV_HALF      (`CLK_HZ / `SYS_CLK_HZ / 2)

`endif

// ==== sig_analyser_model.sv ====
/* Signature analyser stand-in: counts clock strobes inside a window.
   Assumes the selector's gate outputs, all in the clk domain. */
`timescale 1ns/1ps
module sig_analyser_model
(
  input  wire       clk,
  input  wire       sig_window,
  input  wire       sig_start,
  input  wire       sig_stop,
  input  wire       sig_sample,
  output reg  [7:0] samples,
  output reg        ended
);
  // Stop seen since the last start, as the analyser's gate lamp would show
  always @(posedge clk)
    if (sig_start)
      ended <= 1'b0;
    else if (sig_stop)
      ended <= 1'b1;
  // A start clears the count, as the analyser clears its signature
  always @(posedge clk)
    if (sig_start)
      samples <= 8'h00;
    else if (sig_sample && sig_window)
      samples <= samples + 8'h01;
endmodule
